//--- tw_pkg.sv
package tw_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] IDX_CTRL_A  = 10'h080;
    localparam logic [9:0] IDX_CTRL_B  = 10'h081;
    localparam logic [9:0] IDX_COUNT   = 10'h084;
    localparam logic [9:0] IDX_CAPTURE = 10'h086;
    localparam logic [9:0] IDX_CMP_A   = 10'h088;
    localparam logic [9:0] IDX_CMP_B   = 10'h08A;
    localparam logic [9:0] IDX_STATUS  = 10'h090;

    // ==========================================================
    // field layout
    localparam int unsigned CA_OUT_A_LSB  = 6;
    localparam int unsigned CA_OUT_B_LSB  = 4;
    localparam int unsigned CB_MODE_HI_LSB = 3;
    localparam logic [7:0]  CA_RW_MASK    = 8'hF3;
    localparam logic [7:0]  CB_RW_MASK    = 8'hDF;
    localparam int unsigned ST_OVF        = 0;
    localparam int unsigned ST_CMP_A      = 1;
    localparam int unsigned ST_CMP_B      = 2;

    // ==========================================================
    // reset values
    localparam logic [7:0]  RST_CTRL = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // ==========================================================
    // waveform modes and fixed tops
    localparam logic [3:0] MODE_NORMAL   = 4'h0;
    localparam logic [3:0] MODE_PC8      = 4'h1;
    localparam logic [3:0] MODE_PC9      = 4'h2;
    localparam logic [3:0] MODE_PC10     = 4'h3;
    localparam logic [3:0] MODE_CLR_CMP  = 4'h4;
    localparam logic [3:0] MODE_FAST8    = 4'h5;
    localparam logic [3:0] MODE_FAST9    = 4'h6;
    localparam logic [3:0] MODE_FAST10   = 4'h7;
    localparam logic [3:0] MODE_PFC_ICR  = 4'h8;
    localparam logic [3:0] MODE_PFC_OCR  = 4'h9;
    localparam logic [3:0] MODE_PC_ICR   = 4'hA;
    localparam logic [3:0] MODE_PC_OCR   = 4'hB;
    localparam logic [3:0] MODE_CLR_CAP  = 4'hC;
    localparam logic [3:0] MODE_RESERVED = 4'hD;
    localparam logic [3:0] MODE_FAST_ICR = 4'hE;
    localparam logic [3:0] MODE_FAST_OCR = 4'hF;
    localparam logic [15:0] TOP_8   = 16'h00FF;
    localparam logic [15:0] TOP_9   = 16'h01FF;
    localparam logic [15:0] TOP_10  = 16'h03FF;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] BOTTOM  = 16'h0000;

    // ==========================================================
    // compare-output field codes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    typedef enum logic [1:0] {
        SLOPE_UP   = 2'b01,
        SLOPE_DOWN = 2'b10
    } tw_slope_e;

    typedef struct packed {
        logic [11:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } tw_avs_req_s;

    typedef struct packed {
        logic        wait_rq;
        logic [31:0] rdata;
        logic [7:0]  ctl_a;
        logic [7:0]  ctl_b;
        logic [15:0] cnt;
        tw_slope_e   slope;
        logic [15:0] icr;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] ocr_a;
        logic [15:0] ocr_b;
        logic [2:0]  flags;
        logic [1:0]  wave;
        logic [1:0]  pin;
        logic [1:0]  pin_oe;
        logic [1:0]  ovr;
    } tw_state_s;

endpackage

//--- tw_timer.sv
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
module tw_timer (
    // clock and reset
    input  wire logic               MCLK_I,
    input  wire logic               RST_N_I,
    // avalon-mm slave
    input  wire tw_pkg::tw_avs_req_s AVS_REQ_I,
    output logic [31:0]             AVS_READDATA_O,
    output logic                    AVS_WAITREQUEST_O,
    // timer tick and port pins
    input  wire logic               TIMER_TICK_ENABLE_I,
    input  wire logic [1:0]         PORT_DATA_I,
    input  wire logic [1:0]         PORT_DIR_I,
    output logic [1:0]              PIN_O,
    output logic [1:0]              PIN_OE_O,
    output logic [1:0]              PIN_OVERRIDE_O,
    output logic                    OVERFLOW_FLAG_O
);
    import tw_pkg::*;

    // ==========================================================
    // mode helpers
    function automatic logic is_fast(input logic [3:0] m);
        is_fast = (m == MODE_FAST8) || (m == MODE_FAST9) || (m == MODE_FAST10)
               || (m == MODE_FAST_ICR) || (m == MODE_FAST_OCR);
    endfunction

    function automatic logic is_dual(input logic [3:0] m);
        is_dual = (m == MODE_PC8) || (m == MODE_PC9) || (m == MODE_PC10)
               || (m == MODE_PFC_ICR) || (m == MODE_PFC_OCR)
               || (m == MODE_PC_ICR) || (m == MODE_PC_OCR);
    endfunction

    function automatic logic is_immediate(input logic [3:0] m);
        is_immediate = (m == MODE_NORMAL) || (m == MODE_CLR_CMP) || (m == MODE_CLR_CAP);
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] icr,
                                           input logic [15:0] ocra);
        unique case (m)
            MODE_PC8, MODE_FAST8:                             top_of = TOP_8;
            MODE_PC9, MODE_FAST9:                             top_of = TOP_9;
            MODE_PC10, MODE_FAST10:                           top_of = TOP_10;
            MODE_CLR_CMP, MODE_PFC_OCR, MODE_PC_OCR, MODE_FAST_OCR: top_of = ocra;
            MODE_PFC_ICR, MODE_PC_ICR, MODE_CLR_CAP, MODE_FAST_ICR: top_of = icr;
            default:                                          top_of = TOP_MAX;
        endcase
    endfunction

    // channel drives its pin
    function automatic logic connected(input logic [1:0] com, input logic [3:0] m,
                                       input logic chan_a);
        if (com == COM_OFF || m == MODE_RESERVED) begin
            connected = 1'b0;
        end else if (com == COM_TOGGLE && is_fast(m)) begin
            connected = chan_a && (m == MODE_FAST_ICR || m == MODE_FAST_OCR);
        end else if (com == COM_TOGGLE && is_dual(m)) begin
            connected = chan_a && (m == MODE_PFC_OCR || m == MODE_PC_OCR);
        end else begin
            connected = 1'b1;
        end
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ==========================================================
    // reset release
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ==========================================================
    // state
    tw_state_s   st;
    tw_state_s   next_st;
    logic [3:0]  mode;
    logic [15:0] top;
    logic        tick;
    logic        req;
    logic        wr_done;
    logic        cnt_wr;
    logic [9:0]  idx;
    logic [1:0]  com [2];
    logic [1:0]  conn;
    logic [1:0]  match;
    logic [15:0] ocr [2];
    logic        at_top;
    logic        at_bottom;
    logic        upd;

    // mode number from both registers
    // mode assembly
    assign mode = {st.ctl_b[CB_MODE_HI_LSB +: 2], st.ctl_a[1:0]};
    assign top  = top_of(mode, st.icr, st.ocr_a);
    assign tick = TIMER_TICK_ENABLE_I && (mode != MODE_RESERVED);
    assign idx  = AVS_REQ_I.address[11:2];
    assign req  = AVS_REQ_I.read || AVS_REQ_I.write;
    assign wr_done = AVS_REQ_I.write && !st.wait_rq;
    assign cnt_wr  = wr_done && idx == IDX_COUNT && AVS_REQ_I.byteenable[1:0] != 2'h0;
    assign com[0] = st.ctl_a[CA_OUT_A_LSB +: 2];
    assign com[1] = st.ctl_a[CA_OUT_B_LSB +: 2];
    assign ocr[0] = st.ocr_a;
    assign ocr[1] = st.ocr_b;
    assign at_top    = tick && st.cnt == top;
    assign at_bottom = tick && st.cnt == BOTTOM;

    always_comb begin
        next_st = st;
        conn    = 2'h0;
        match   = 2'h0;
        upd     = 1'b0;

        // ======================================================
        // bus slave: one wait cycle, then complete
        next_st.wait_rq = !(req && st.wait_rq);
        if (AVS_REQ_I.read && st.wait_rq) begin
            unique case (idx)
                IDX_CTRL_A:  next_st.rdata = {24'h000000, st.ctl_a};
                IDX_CTRL_B:  next_st.rdata = {24'h000000, st.ctl_b};
                IDX_COUNT:   next_st.rdata = {16'h0000, st.cnt};
                IDX_CAPTURE: next_st.rdata = {16'h0000, st.icr};
                IDX_CMP_A:   next_st.rdata = {16'h0000, st.buf_a};
                IDX_CMP_B:   next_st.rdata = {16'h0000, st.buf_b};
                IDX_STATUS:  next_st.rdata = {29'h00000000, st.flags};
                default:     next_st.rdata = 32'h00000000;
            endcase
        end

        // ======================================================
        // counting sequence
        if (tick) begin
            if (is_dual(mode)) begin
                if (st.slope == SLOPE_UP) begin
                    if (st.cnt == top) begin
                        next_st.slope = SLOPE_DOWN;
                        next_st.cnt   = st.cnt - 16'h0001;
                    end else begin
                        next_st.cnt = st.cnt + 16'h0001;
                    end
                end else if (st.cnt == BOTTOM) begin
                    next_st.slope = SLOPE_UP;
                    next_st.cnt   = st.cnt + 16'h0001;
                end else begin
                    next_st.cnt = st.cnt - 16'h0001;
                end
            end else begin
                next_st.cnt = at_top ? BOTTOM : st.cnt + 16'h0001;
            end
        end

        // ======================================================
        // buffer copy points
        if (mode == MODE_PFC_ICR || mode == MODE_PFC_OCR) begin
            upd = at_bottom;
        end else if (is_dual(mode)) begin
            upd = at_top;
        end else if (is_fast(mode)) begin
            upd = at_top;
        end
        if (upd) begin
            next_st.ocr_a = st.buf_a;
            next_st.ocr_b = st.buf_b;
        end

        // ======================================================
        // compare outputs
        for (int i = 0; i < 2; i++) begin
            match[i] = tick && st.cnt == ocr[i];
            conn[i]  = connected(com[i], mode, i == 0);
            if (conn[i]) begin
                if (is_immediate(mode)) begin
                    if (match[i]) begin
                        next_st.wave[i] = (com[i] == COM_TOGGLE) ? !st.wave[i] : com[i][0];
                    end
                end else if (com[i] == COM_TOGGLE) begin
                    if (match[i]) begin
                        next_st.wave[i] = !st.wave[i];
                    end
                end else if (is_fast(mode)) begin
                    if (at_top) begin
                        next_st.wave[i] = !com[i][0];
                    end else if (match[i] && ocr[i] != top) begin
                        next_st.wave[i] = com[i][0];
                    end
                end else if (ocr[i] == BOTTOM) begin
                    next_st.wave[i] = com[i][0];
                end else if (ocr[i] == top) begin
                    next_st.wave[i] = !com[i][0];
                end else if (match[i]) begin
                    next_st.wave[i] = (st.slope == SLOPE_UP) ? com[i][0] : !com[i][0];
                end
            end
            next_st.pin_oe[i] = PORT_DIR_I[i];
            next_st.pin[i]    = conn[i] ? st.wave[i] : PORT_DATA_I[i];
            next_st.ovr[i]    = conn[i];
        end

        // ======================================================
        // register writes
        if (wr_done) begin
            unique case (idx)
                IDX_CTRL_A: if (AVS_REQ_I.byteenable[0]) begin
                    next_st.ctl_a = AVS_REQ_I.writedata[7:0] & CA_RW_MASK;
                end
                IDX_CTRL_B: if (AVS_REQ_I.byteenable[0]) begin
                    next_st.ctl_b = AVS_REQ_I.writedata[7:0] & CB_RW_MASK;
                end
                IDX_COUNT:   next_st.cnt = merge16(st.cnt, AVS_REQ_I.writedata,
                                                   AVS_REQ_I.byteenable);
                IDX_CAPTURE: next_st.icr = merge16(st.icr, AVS_REQ_I.writedata,
                                                   AVS_REQ_I.byteenable);
                IDX_CMP_A: begin
                    next_st.buf_a = merge16(st.buf_a, AVS_REQ_I.writedata,
                                            AVS_REQ_I.byteenable);
                    if (is_immediate(mode)) begin
                        next_st.ocr_a = next_st.buf_a;
                    end
                end
                IDX_CMP_B: begin
                    next_st.buf_b = merge16(st.buf_b, AVS_REQ_I.writedata,
                                            AVS_REQ_I.byteenable);
                    if (is_immediate(mode)) begin
                        next_st.ocr_b = next_st.buf_b;
                    end
                end
                IDX_STATUS: if (AVS_REQ_I.byteenable[0]) begin
                    next_st.flags = st.flags & ~AVS_REQ_I.writedata[2:0];
                end
                default: ;
            endcase
        end

        // ======================================================
        // flag sets win over clears
        if (match[0]) begin
            next_st.flags[ST_CMP_A] = 1'b1;
        end
        if (match[1]) begin
            next_st.flags[ST_CMP_B] = 1'b1;
        end
        if (is_dual(mode)) begin
            if (at_bottom) begin
                next_st.flags[ST_OVF] = 1'b1;
            end
        end else if (is_fast(mode)) begin
            if (at_top) begin
                next_st.flags[ST_OVF] = 1'b1;
            end
        end else if (tick && st.cnt == TOP_MAX) begin
            next_st.flags[ST_OVF] = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{wait_rq: 1'b1, rdata: 32'h00000000, ctl_a: RST_CTRL, ctl_b: RST_CTRL,
                    cnt: RST_WORD, slope: SLOPE_UP, icr: RST_WORD, buf_a: RST_WORD,
                    buf_b: RST_WORD, ocr_a: RST_WORD, ocr_b: RST_WORD, flags: 3'h0,
                    wave: 2'h0, pin: 2'h0, pin_oe: 2'h0, ovr: 2'h0};
        end else begin
            st <= next_st;
        end
    end

    assign AVS_READDATA_O    = st.rdata;
    assign AVS_WAITREQUEST_O = st.wait_rq;
    assign PIN_O             = st.pin;
    assign PIN_OE_O          = st.pin_oe;
    assign PIN_OVERRIDE_O    = st.ovr;
    assign OVERFLOW_FLAG_O   = st.flags[ST_OVF];

    // ==========================================================
    // checks
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!rst_n);

    count_hold_a: assert property (!TIMER_TICK_ENABLE_I && !cnt_wr |=> $stable(st.cnt))
        else $error("counter moved without tick");
    pfc_update_a: assert property ((mode == MODE_PFC_ICR || mode == MODE_PFC_OCR)
            && at_bottom && !wr_done |=> st.ocr_a == $past(st.buf_a))
        else $error("buffer not copied at bottom");
    dual_ovf_a: assert property (is_dual(mode) && at_bottom |=> st.flags[ST_OVF])
        else $error("overflow not flagged at bottom");
    port_keep_a: assert property (com[0] == COM_OFF && !wr_done
            |=> PIN_O[0] == $past(PORT_DATA_I[0]) && !PIN_OVERRIDE_O[0])
        else $error("pin not left to port");
    toggle_match_a: assert property (is_immediate(mode) && match[0] && com[0] == COM_TOGGLE
            |=> st.wave[0] != $past(st.wave[0]))
        else $error("no toggle on match");
    fast_bottom_a: assert property (is_fast(mode) && at_top && com[0] == COM_CLEAR
            && !wr_done |=> st.wave[0] ##1 PIN_O[0] == 1'b1)
        else $error("fast mode bottom set missing");
    toggle_b_off_a: assert property ((is_fast(mode) || is_dual(mode)) && com[1] == COM_TOGGLE
            && !wr_done |=> !PIN_OVERRIDE_O[1])
        else $error("channel B driven in toggle field");
    fast_top_ign_a: assert property (is_fast(mode) && match[0] && st.ocr_a == top
            && com[0][1] |=> st.wave[0] != $past(st.ctl_a[CA_OUT_A_LSB]))
        else $error("match at top acted on");
    dual_up_clr_a: assert property (is_dual(mode) && match[0] && st.slope == SLOPE_UP
            && com[0] == COM_CLEAR && st.ocr_a != BOTTOM && st.ocr_a != top |=> !st.wave[0])
        else $error("no clear on up-count match");
    dual_low_a: assert property (is_dual(mode) && com[0] == COM_CLEAR
            && st.ocr_a == BOTTOM && !wr_done |=> !st.wave[0] ##1 !st.wave[0])
        else $error("bottom compare not constant low");
    max_ovf_a: assert property (mode == MODE_NORMAL && tick && st.cnt == TOP_MAX
            && !cnt_wr |=> st.flags[ST_OVF] && st.cnt == BOTTOM)
        else $error("normal mode overflow wrong");

endmodule

//--- tw_port_pad.sv
`timescale 1ns/1ns
module tw_port_pad (
    // clock
    input  wire logic       clk_i,
    // compare outputs from the block
    input  wire logic [1:0] pin_i,
    input  wire logic [1:0] pin_oe_i,
    // pad level seen outside
    output logic [1:0]      pad_o
);
    logic [1:0] last;

    // ========================================
    // released pad wanders, never holds
    always_ff @(posedge clk_i) begin
        last <= pad_o;
    end

    assign pad_o = (pin_oe_i & pin_i) | (~pin_oe_i & ~last);
endmodule

//--- tw_timer_test.sv
`timescale 1ns/1ns
module tw_timer_test;
    import tw_pkg::*;
    logic        mclk;
    logic        rst_n;
    tw_avs_req_s req;
    logic [31:0] rdata;
    logic        wait_rq;
    logic        tick;
    logic [1:0]  port_data;
    logic [1:0]  port_dir;
    logic [1:0]  pin;
    logic [1:0]  pin_oe;
    logic [1:0]  pin_ovr;
    logic        ovf;
    logic [1:0]  pad;
    int          bad_count = 0;
    int          num_checks = 0;

    tw_timer tw_timer_inst (
        .MCLK_I(mclk), .RST_N_I(rst_n), .AVS_REQ_I(req), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wait_rq), .TIMER_TICK_ENABLE_I(tick), .PORT_DATA_I(port_data),
        .PORT_DIR_I(port_dir), .PIN_O(pin), .PIN_OE_O(pin_oe), .PIN_OVERRIDE_O(pin_ovr),
        .OVERFLOW_FLAG_O(ovf));
    tw_port_pad tw_port_pad_inst (.clk_i(mclk), .pin_i(pin), .pin_oe_i(pin_oe), .pad_o(pad));

    always #4 mclk = ~mclk;

    // ========================================
    // shared tasks
    task automatic end_of_test();
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        req.address <= {idx, 2'b00};
        req.read <= ~wr;
        req.write <= wr;
        req.writedata <= wd;
        req.byteenable <= 4'hF;
        // waitrequest sampled at each rising edge
        do begin
            @(posedge mclk);
            n++;
        end while (wait_rq !== 1'b0 && n < 50);
        if (wait_rq !== 1'b0) begin
            bad_count++;
            end_of_test();
        end
        rd = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        check(nm, exp, d);
    endtask

    task automatic set_mode(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb);
        wr(IDX_CTRL_A, {24'h0, ca, cb, 4'h0});
        wr(IDX_CTRL_B, {24'h0, 3'b000, m[3:2], 3'b000});
        wr(IDX_CTRL_A, {24'h0, ca, cb, 2'b00, m[1:0]});
        wr(IDX_COUNT, 32'h0);
    endtask

    task automatic duty(input string nm, input int ch, input int n, input int exp, input int st);
        int h;
        h = 0;
        repeat (st) @(negedge mclk);
        repeat (n) begin
            @(negedge mclk);
            h += int'(pad[ch]);
        end
        check(nm, exp, h);
    endtask

    // ========================================
    // scenarios
    task automatic test_regs();
        rd_chk("ctrl_a", IDX_CTRL_A, 32'h0);
        rd_chk("ctrl_b", IDX_CTRL_B, 32'h0);
        check("pin_ovr", 32'h0, {30'h0, pin_ovr});
        check("pin_port", {30'h0, port_data}, {30'h0, pin});
        check("pin_oe_off", 32'h0, {30'h0, pin_oe});
        wr(IDX_CTRL_A, 32'hFF);
        rd_chk("ctrl_a_bits", IDX_CTRL_A, {24'h0, CA_RW_MASK});
        wr(IDX_CTRL_B, 32'hFF);
        rd_chk("ctrl_b_bits", IDX_CTRL_B, {24'h0, CB_RW_MASK});
        wr(10'h0F0, 32'h5A);
        rd_chk("unmapped", 10'h0F0, 32'h0);
    endtask

    task automatic test_normal();
        logic [1:0] codes [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_TOGGLE};
        logic       lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        port_dir <= 2'b11;
        tick <= 1'b1;
        set_mode(MODE_NORMAL, COM_SET, COM_OFF);
        wr(IDX_CMP_A, 32'h5);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_CTRL_A, {24'h0, codes[i], COM_OFF, 4'h0});
            wr(IDX_COUNT, 32'h0);
            repeat (12) @(negedge mclk);
            check("normal_pad_a", {31'h0, lvl[i]}, {31'h0, pad[0]});
        end
        wr(IDX_STATUS, 32'h7);
        wr(IDX_COUNT, 32'hFFF0);
        repeat (30) @(negedge mclk);
        check("normal_ovf", 32'h1, {31'h0, ovf});
        check("pin_oe_on", 32'h3, {30'h0, pin_oe});
    endtask

    task automatic test_clr();
        set_mode(MODE_CLR_CMP, COM_TOGGLE, COM_OFF);
        wr(IDX_CMP_A, 32'h5);
        wr(IDX_COUNT, 32'h0);
        wr(IDX_STATUS, 32'h7);
        duty("clr_toggle", 0, 120, 60, 20);
        check("clr_ovf", 32'h0, {31'h0, ovf});
    endtask

    task automatic test_fast();
        set_mode(MODE_FAST8, COM_CLEAR, COM_SET);
        wr(IDX_CMP_A, 32'h10);
        wr(IDX_CMP_B, 32'h10);
        check("fast_ovr", 32'h3, {30'h0, pin_ovr});
        duty("fast_noninv", 0, 256, 17, 600);
        duty("fast_inv", 1, 256, 239, 0);
        set_mode(MODE_FAST8, COM_TOGGLE, COM_TOGGLE);
        repeat (3) @(negedge mclk);
        check("fast8_tgl_ovr", 32'h0, {30'h0, pin_ovr});
        check("fast8_tgl_pin", {30'h0, port_data}, {30'h0, pin});
        set_mode(MODE_FAST_OCR, COM_TOGGLE, COM_TOGGLE);
        repeat (3) @(negedge mclk);
        check("fast15_tgl_ovr", 32'h1, {30'h0, pin_ovr});
        duty("fast15_toggle", 0, 340, 170, 300);
        set_mode(MODE_FAST_OCR, COM_CLEAR, COM_OFF);
        duty("fast_top_match", 0, 340, 340, 300);
    endtask

    task automatic test_dual();
        set_mode(MODE_PC8, COM_CLEAR, COM_SET);
        wr(IDX_CMP_A, 32'h40);
        wr(IDX_CMP_B, 32'h40);
        duty("dual_noninv", 0, 510, 128, 1100);
        duty("dual_inv", 1, 510, 382, 0);
        set_mode(MODE_PC8, COM_CLEAR, COM_CLEAR);
        wr(IDX_CMP_A, 32'h0);
        wr(IDX_CMP_B, 32'hFF);
        duty("dual_bottom", 0, 510, 0, 1100);
        duty("dual_top", 1, 510, 510, 0);
        wr(IDX_CMP_A, 32'h40);
        // one full period so compare A takes the new value
        repeat (520) @(negedge mclk);
        set_mode(MODE_PC_OCR, COM_TOGGLE, COM_TOGGLE);
        repeat (3) @(negedge mclk);
        check("dual_tgl_ovr", 32'h1, {30'h0, pin_ovr});
        duty("dual_toggle", 0, 256, 128, 600);
        set_mode(MODE_PFC_OCR, COM_TOGGLE, COM_TOGGLE);
        wr(IDX_STATUS, 32'h7);
        duty("pfc_toggle", 0, 256, 128, 600);
        check("pfc_tgl_ovr", 32'h1, {30'h0, pin_ovr});
        check("dual_ovf", 32'h1, {31'h0, ovf});
    endtask

    // ========================================
    // main sequence
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        req = '0;
        tick = 1'b0;
        port_data = 2'b10;
        port_dir = 2'b00;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        test_regs();
        test_normal();
        test_clr();
        test_fast();
        test_dual();
        end_of_test();
    end
endmodule
